//--- rtl/empty_placeholder_removed.sv
// intentionally contains no design; kept minimal
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- rtl/tchp_host_port.sv
// control host port: register access, gpio, interrupt pin, transmit high-z
`timescale 1ns/100ps
`default_nettype none
module tchp_host_port
    import tchp_pkg::*;
#(
    parameter int READY_CYCLES = tchp_pkg::READY_CYC
) (
    // clock and reset pin
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // host bus pins
    input  wire logic       chipSelN,
    input  wire logic [10:0] addrPin,
    input  wire logic [7:0] dataIn,
    output logic      [7:0] dataOut,
    output logic      [7:0] dataOe,
    input  wire logic       rwSdi,
    input  wire logic       strobeSclk,
    input  wire logic       parallelBusStyle,
    input  wire logic       serialHostSelect,
    // general purpose pins
    input  wire logic [1:0] gpioIn,
    output logic      [1:0] gpioOut,
    output logic      [1:0] gpioOe,
    // line transmitters
    input  wire logic       txHighImpedance,
    output logic      [7:0] lineTxPairOe,
    // interrupt
    input  wire logic [7:0] intEvent,
    output logic            intOut,
    output logic            intOe,
    output logic            deviceReady
);
    import tchp_pkg::*;

    localparam int CW = $clog2(READY_CYCLES + 1);
    localparam logic [CW-1:0] READY_LAST = CW'(READY_CYCLES);

    // ----------------------------------------
    // reset filter
    // ----------------------------------------
    // short glitches on the pin must not reset, so the pin is filtered first
    logic [1:0]             rstSync_r;
    logic [RST_MIN_CYC-1:0] lowHist_r;
    logic                   intRstN_r;

    always_ff @(posedge clk_sys) begin
        rstSync_r <= {rstSync_r[0], rst_b};
        lowHist_r <= {lowHist_r[RST_MIN_CYC-2:0], ~rstSync_r[1]};
        intRstN_r <= ~(&lowHist_r);
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    tchp_ctl_s   ctlMeta_r, ctl_r;
    logic [10:0] addrMeta_r, addr_r;
    logic [7:0]  dataMeta_r, data_r;
    logic [1:0]  gpioMeta_r, gpioSync_r;
    logic        sclkPrev_r;

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            ctlMeta_r  <= '1;
            ctl_r      <= '1;
            addrMeta_r <= 11'h000;
            addr_r     <= 11'h000;
            dataMeta_r <= 8'h00;
            data_r     <= 8'h00;
            gpioMeta_r <= 2'h0;
            gpioSync_r <= 2'h0;
            sclkPrev_r <= 1'b1;
        end else begin
            ctlMeta_r  <= '{chipSelN, strobeSclk, rwSdi, parallelBusStyle,
                           serialHostSelect, txHighImpedance};
            ctl_r      <= ctlMeta_r;
            addrMeta_r <= addrPin;
            addr_r     <= addrMeta_r;
            dataMeta_r <= dataIn;
            data_r     <= dataMeta_r;
            gpioMeta_r <= gpioIn;
            gpioSync_r <= gpioMeta_r;
            sclkPrev_r <= ctl_r.strobe;
        end
    end

    // ----------------------------------------
    // ready timer and test mode exit
    // ----------------------------------------
    logic [CW-1:0] readyCnt_r;
    logic          ready_r;
    logic          testCleared_r;

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            readyCnt_r <= '0;
            ready_r    <= 1'b0;
        end else if (readyCnt_r != READY_LAST) begin
            readyCnt_r <= readyCnt_r + CW'(1);
        end else begin
            ready_r    <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            testCleared_r <= 1'b0;
        end else if (ctl_r.csN) begin
            testCleared_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0] gpioDir_r, gpioLvl_r;
    logic [7:0] intStat_r, intMask_r;
    tchp_wr_s   wr;

    function automatic logic [7:0] regRead(input logic [10:0] a, input logic [1:0] dir,
                                           input logic [1:0] lvl, input logic [1:0] pin,
                                           input logic [7:0] st, input logic [7:0] mk);
        logic [1:0] shown;
        shown = (dir & lvl) | (~dir & pin);
        case (a)
            ADDR_GPIO:     regRead = {4'h0, shown, dir};
            ADDR_INT_STAT: regRead = st;
            ADDR_INT_MASK: regRead = mk;
            default:       regRead = RD_UNMAPPED;
        endcase
    endfunction

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            gpioDir_r <= GPIO_DIR_RST;
            gpioLvl_r <= GPIO_LVL_RST;
        end else if (wr.en && wr.addr == ADDR_GPIO) begin
            gpioDir_r <= wr.data[GPIO_DIR_LSB +: 2];
            gpioLvl_r <= wr.data[GPIO_LVL_LSB +: 2];
        end
    end

    // status bits are write-one-to-clear; a new event wins over the clear
    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            intStat_r <= INT_STAT_RST;
            intMask_r <= INT_MASK_RST;
        end else begin
            if (wr.en && wr.addr == ADDR_INT_STAT) begin
                intStat_r <= (intStat_r & ~wr.data) | intEvent;
            end else begin
                intStat_r <= intStat_r | intEvent;
            end
            if (wr.en && wr.addr == ADDR_INT_MASK) begin
                intMask_r <= wr.data;
            end
        end
    end

    // ----------------------------------------
    // parallel access
    // ----------------------------------------
    tchp_state_e state_r;
    logic        pRead, pWrite, pTake, holdRead_r;
    logic [7:0]  pRdData;

    assign pRead  = ctl_r.style ? ~ctl_r.strobe
                                : (~ctl_r.strobe & ctl_r.rwSdi);
    assign pWrite = ctl_r.style ? ~ctl_r.rwSdi
                                : (~ctl_r.strobe & ~ctl_r.rwSdi);
    assign pTake  = (state_r == ST_IDLE) && !ctl_r.csN && !ctl_r.spiSel
                    && (pRead || pWrite);
    assign pRdData = regRead(addr_r, gpioDir_r, gpioLvl_r, gpioSync_r,
                             intStat_r, intMask_r);

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            state_r    <= ST_WAIT;
            holdRead_r <= 1'b0;
        end else begin
            case (state_r)
                ST_WAIT: begin
                    if (ready_r && testCleared_r && ctl_r.csN) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (pTake) begin
                        state_r    <= ST_HOLD;
                        holdRead_r <= pRead;
                    end
                end
                ST_HOLD: begin
                    if (ctl_r.csN) begin
                        state_r    <= ST_IDLE;
                        holdRead_r <= 1'b0;
                    end
                end
                default: state_r <= ST_WAIT;
            endcase
        end
    end

    // ----------------------------------------
    // serial access
    // ----------------------------------------
    logic        spiAct, sclkRise, sclkFall;
    logic [4:0]  spiBits_r;
    logic [15:0] spiSh_r, spiHdr_r;
    logic [7:0]  spiOut_r;
    logic        spiWr;

    assign spiAct   = ctl_r.spiSel && !ctl_r.csN && state_r != ST_WAIT;
    assign sclkRise = ctl_r.strobe && !sclkPrev_r;
    assign sclkFall = !ctl_r.strobe && sclkPrev_r;
    assign spiWr    = spiAct && sclkRise && spiBits_r == SPI_DAT_LAST && !spiHdr_r[SPI_RD_BIT];

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            spiBits_r <= 5'h00;
            spiSh_r   <= 16'h0000;
            spiHdr_r  <= 16'h0000;
            spiOut_r  <= 8'h00;
        end else if (!spiAct) begin
            spiBits_r <= 5'h00;
        end else if (sclkRise && spiBits_r != SPI_FRAME_BITS) begin
            spiSh_r   <= {spiSh_r[14:0], ctl_r.rwSdi};
            spiBits_r <= spiBits_r + 5'h01;
            if (spiBits_r == SPI_HDR_LAST) begin
                spiHdr_r <= {spiSh_r[14:0], ctl_r.rwSdi};
                // the last address bit is still on the pin, not yet in the shifter
                spiOut_r <= regRead({spiSh_r[9:0], ctl_r.rwSdi}, gpioDir_r, gpioLvl_r,
                                    gpioSync_r, intStat_r, intMask_r);
            end
        end else if (sclkFall && spiBits_r > SPI_HDR_LAST && spiHdr_r[SPI_RD_BIT]) begin
            spiOut_r <= {spiOut_r[6:0], 1'b0};
        end
    end

    always_comb begin
        wr.en   = (pTake && pWrite && !pRead) || spiWr;
        wr.addr = spiWr ? spiHdr_r[10:0] : addr_r;
        wr.data = spiWr ? {spiSh_r[6:0], ctl_r.rwSdi} : data_r;
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    logic spiRdPhase;
    assign spiRdPhase = spiAct && spiBits_r > SPI_HDR_LAST && spiHdr_r[SPI_RD_BIT];

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            dataOut <= 8'h00;
            dataOe  <= 8'h00;
        end else if (ctl_r.spiSel) begin
            if (sclkFall && spiRdPhase && spiBits_r != SPI_FRAME_BITS + 5'h01) begin
                dataOut <= {7'h00, spiOut_r[7]};
            end
            dataOe <= {7'h00, spiRdPhase};
        end else begin
            if (pTake && pRead) begin
                dataOut <= pRdData;
            end
            dataOe <= {8{(holdRead_r || (pTake && pRead)) && pRead && !ctl_r.csN}};
        end
    end

    always_ff @(posedge clk_sys or negedge intRstN_r) begin
        if (!intRstN_r) begin
            gpioOut      <= 2'h0;
            gpioOe       <= 2'h0;
            lineTxPairOe <= 8'h00;
            intOe        <= 1'b0;
        end else begin
            gpioOut      <= gpioLvl_r;
            gpioOe       <= gpioDir_r;
            lineTxPairOe <= {8{~ctl_r.txFloat}};
            intOe        <= |(intStat_r & ~intMask_r);
        end
    end

    assign intOut      = 1'b0;
    assign deviceReady = ready_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!intRstN_r);

    sequence s_cs_high;
        ctl_r.csN;
    endsequence
    sequence s_take;
        pTake ##1 (state_r == ST_HOLD);
    endsequence

    a_reset_width: assert property (@(posedge clk_sys) disable iff (1'b0)
        $fell(intRstN_r) |-> $past(&lowHist_r)) else $error("reset without long low");
    a_ready_gate: assert property (wr.en |-> ready_r && testCleared_r)
        else $error("write before ready");
    a_gpio_drive: assert property (wr.en && wr.addr == ADDR_GPIO |-> ##2
        gpioOut == $past(wr.data[3:2], 2) && gpioOe == $past(wr.data[1:0], 2))
        else $error("gpio not driven from write");
    a_gpio_input: assert property (addr_r == ADDR_GPIO && !gpioDir_r[0] |->
        pRdData[2] == gpioSync_r[0]) else $error("gpio input level wrong");
    a_tx_float: assert property (ctl_r.txFloat |=> lineTxPairOe == 8'h00)
        else $error("transmitters driven in high-z");
    a_int_level: assert property ((|(intStat_r & ~intMask_r)) |=> intOe)
        else $error("interrupt not asserted");
    a_int_release: assert property (!(|(intStat_r & ~intMask_r)) |=> !intOe)
        else $error("interrupt stuck");
    a_cs_ignore: assert property (s_cs_high |-> !wr.en && !pTake)
        else $error("access with chip select high");
    a_one_access: assert property (s_take |-> !pTake)
        else $error("second access in one select");
    a_style_read: assert property (pTake && pRead && !ctl_r.style |-> ctl_r.rwSdi)
        else $error("strobe style read decode");
    a_sdo_fall: assert property (ctl_r.spiSel && $changed(dataOut[0]) |-> $past(sclkFall))
        else $error("serial out not on falling edge");
endmodule
`default_nettype wire

//--- rtl/tchp_pkg.sv
// constants and types of the transceiver control host port
package tchp_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS      = 25;
    localparam int RST_MIN_NS  = 100;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_MS    = 2;
    localparam int READY_CYC   = (READY_MS * 1000000) / CLK_NS;
    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam logic [10:0] ADDR_GPIO      = 11'h006;
    localparam logic [10:0] ADDR_INT_STAT  = 11'h0f0;
    localparam logic [10:0] ADDR_INT_MASK  = 11'h0f1;
    localparam int          GPIO_DIR_LSB   = 0;
    localparam int          GPIO_LVL_LSB   = 2;
    localparam logic [1:0]  GPIO_DIR_RST   = 2'h0;
    localparam logic [1:0]  GPIO_LVL_RST   = 2'h0;
    localparam logic [7:0]  INT_STAT_RST   = 8'h00;
    localparam logic [7:0]  INT_MASK_RST   = 8'hff;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
    // ----------------------------------------
    // serial frame: read flag, 4 spare, 11 address, 8 data
    // ----------------------------------------
    localparam logic [4:0]  SPI_HDR_LAST   = 5'h0f;
    localparam logic [4:0]  SPI_DAT_LAST   = 5'h17;
    localparam logic [4:0]  SPI_FRAME_BITS = 5'h18;
    localparam int          SPI_RD_BIT     = 15;

    typedef struct packed {
        logic csN;
        logic strobe;
        logic rwSdi;
        logic style;
        logic spiSel;
        logic txFloat;
    } tchp_ctl_s;

    typedef struct packed {
        logic        en;
        logic [10:0] addr;
        logic [7:0]  data;
    } tchp_wr_s;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_HOLD = 3'b100
    } tchp_state_e;
endpackage

//--- verification/tchp_host_model.sv
// host processor model that drives the control port pins
`timescale 1ns/100ps
`default_nettype none
module tchp_host_model (
    // clock and device answer
    input  wire logic        clk_sys,
    input  wire logic [7:0]  dataOut,
    input  wire logic [7:0]  dataOe,
    // host bus pins
    output var logic         chipSelN,
    output var logic [10:0]  addrPin,
    output var logic [7:0]   dataIn,
    output var logic         rwSdi,
    output var logic         strobeSclk,
    output var logic         parallelBusStyle,
    output var logic         serialHostSelect
);
    // chip select starts low on purpose: the first access must find test mode
    initial begin
        chipSelN = 1'b0;
        addrPin = 11'h000;
        dataIn = 8'h00;
        rwSdi = 1'b1;
        strobeSclk = 1'b1;
        parallelBusStyle = 1'b0;
        serialHostSelect = 1'b0;
    end
    // one byte per chip select low period, setup held 4 cycles before the strobe
    task automatic access(input bit sty, input bit rd, input bit noCs,
                          input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        @(posedge clk_sys);
        chipSelN         <= noCs;
        serialHostSelect <= 1'b0;
        parallelBusStyle <= sty;
        addrPin          <= a;
        dataIn           <= rd ? ~d : d;
        rwSdi            <= sty ? 1'b1 : rd;
        repeat (4) @(posedge clk_sys);
        if (sty && !rd) rwSdi <= 1'b0;
        else strobeSclk <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk_sys);
            if (rd && dataOe === 8'hff) q = dataOut;
        end
        chipSelN   <= 1'b1;
        strobeSclk <= 1'b1;
        rwSdi      <= 1'b1;
        dataIn     <= ~dataIn; // a released bus does not keep the last byte
        repeat (4) @(posedge clk_sys);
    endtask
    // 24-bit frame, read flag first; clock halves of 5 cycles beat the 3-cycle sync
    task automatic serial(input bit rd, input logic [10:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 4'h0, a, d};
        q = 8'h00;
        @(posedge clk_sys);
        serialHostSelect <= 1'b1;
        addrPin          <= 11'h000;
        chipSelN         <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 23; i >= 0; i--) begin
            strobeSclk <= 1'b0;
            rwSdi      <= f[i];
            repeat (5) @(posedge clk_sys);
            if (i < 8) q[i] = dataOut[0];
            strobeSclk <= 1'b1;
            repeat (5) @(posedge clk_sys);
        end
        chipSelN <= 1'b1;
        repeat (4) @(posedge clk_sys);
        serialHostSelect <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/transceiver_control_host_port_tb.sv
// self-checking bench of the transceiver control host port
`timescale 1ns/100ps
`default_nettype none
module transceiver_control_host_port_tb;
    import tchp_pkg::*;
    localparam int RDY = 20;
    logic        clk_sys, rst_b, txHighImpedance, chipSelN, rwSdi, strobeSclk;
    logic        parallelBusStyle, serialHostSelect, intOut, intOe, deviceReady;
    logic [10:0] addrPin;
    logic [7:0]  dataIn, dataOut, dataOe, lineTxPairOe, intEvent, r;
    logic [1:0]  gpioIn, gpioOut, gpioOe;
    logic [31:0] v;
    int          n_errors, samples_checked, seed, mDir, mLvl, mStat, mMask;

    tchp_host_port #(.READY_CYCLES(RDY)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .chipSelN(chipSelN), .addrPin(addrPin),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .rwSdi(rwSdi),
        .strobeSclk(strobeSclk), .parallelBusStyle(parallelBusStyle),
        .serialHostSelect(serialHostSelect), .gpioIn(gpioIn), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .txHighImpedance(txHighImpedance), .lineTxPairOe(lineTxPairOe),
        .intEvent(intEvent), .intOut(intOut), .intOe(intOe), .deviceReady(deviceReady));
    tchp_host_model host (
        .clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe), .chipSelN(chipSelN),
        .addrPin(addrPin), .dataIn(dataIn), .rwSdi(rwSdi), .strobeSclk(strobeSclk),
        .parallelBusStyle(parallelBusStyle), .serialHostSelect(serialHostSelect));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] gpioExp();
        logic [1:0] l;
        for (int i = 0; i < 2; i++) l[i] = mDir[i] ? mLvl[i] : gpioIn[i];
        return {4'h0, l, mDir[1:0]};
    endfunction
    task automatic rdChk(input bit sty, input logic [10:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.access(sty, 1'b1, 1'b0, a, 8'h00, q);
        check(q, e);
    endtask
    task automatic wr(input bit sty, input logic [10:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(sty, 1'b0, 1'b0, a, d, q);
    endtask
    task automatic doRst(input int cyc);
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (cyc) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic waitReady();
        for (int n = 0; n < 200 && deviceReady !== 1'b1; n++) @(posedge clk_sys);
        check({7'h0, deviceReady}, 8'h01);
    endtask
    task automatic intChk();
        repeat (3) @(posedge clk_sys);
        check({6'h0, intOut, intOe}, {7'h0, (mStat & ~mMask & 8'hff) != 0});
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, scenarios
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst_b = 1'b0;
        txHighImpedance = 1'b0;
        gpioIn = 2'h0;
        intEvent = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        seed = 37293;
        mDir = 0;
        mLvl = 0;
        mStat = 0;
        mMask = 8'hff;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        // the filter releases late and the high-z pin is synced, so wait then look off the edge
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        check(lineTxPairOe, 8'hff);
        check({gpioOe, gpioOut, 2'h0, intOe, deviceReady}, 8'h00);
        waitReady();
        wr(1'b0, ADDR_GPIO, 8'h0f);
        rdChk(1'b0, ADDR_GPIO, gpioExp());
        for (int k = 0; k < 6; k++) begin
            v = $random(seed);
            gpioIn <= v[5:4];
            wr(k[0], ADDR_GPIO, v[7:0]);
            mDir = v[1:0];
            mLvl = v[3:2];
            check({gpioOe, gpioOut & gpioOe, 4'h0}, {v[1:0], v[3:2] & v[1:0], 4'h0});
            rdChk(!k[0], ADDR_GPIO, gpioExp());
        end
        rdChk(1'b1, 11'h7ff, RD_UNMAPPED);
        wr(1'b0, ADDR_GPIO | 11'h400, ~gpioExp());
        host.access(1'b1, 1'b0, 1'b1, ADDR_GPIO, ~gpioExp(), r);
        rdChk(1'b0, ADDR_GPIO, gpioExp());
        v = $random(seed) | 32'h1;
        @(posedge clk_sys) intEvent <= v[7:0];
        @(posedge clk_sys) intEvent <= 8'h00;
        mStat = v[7:0];
        intChk();
        wr(1'b1, ADDR_INT_MASK, 8'hfe);
        mMask = 8'hfe;
        intChk();
        rdChk(1'b0, ADDR_INT_STAT, v[7:0]);
        wr(1'b0, ADDR_INT_STAT, 8'hfe);
        mStat = 1;
        intChk();
        wr(1'b1, ADDR_INT_STAT, 8'h01);
        mStat = 0;
        intChk();
        @(posedge clk_sys) txHighImpedance <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(lineTxPairOe, 8'h00);
        @(posedge clk_sys) txHighImpedance <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(lineTxPairOe, 8'hff);
        v = $random(seed);
        host.serial(1'b0, ADDR_GPIO, {4'h0, v[3:0]}, r);
        mDir = v[1:0];
        mLvl = v[3:2];
        host.serial(1'b1, ADDR_GPIO, 8'h00, r);
        check(r, gpioExp());
        rdChk(1'b1, ADDR_GPIO, gpioExp());
        doRst(3);
        rdChk(1'b0, ADDR_GPIO, gpioExp());
        doRst(6);
        mDir = 0;
        mLvl = 0;
        check({7'h0, deviceReady}, 8'h00);
        wr(1'b0, ADDR_GPIO, 8'h0f);
        waitReady();
        rdChk(1'b0, ADDR_GPIO, gpioExp());
        report_and_stop();
    end
endmodule
`default_nettype wire
